// >>> ibr_responder.sv
// general bus command responder: addressing, remote/local, lockout, clears,
// bus trigger and serial poll with its status byte source handshake
// assumes all inputs except arst_n are synchronous to mclk; the device-dependent parser is outside
`timescale 1ns/1ps
module ibr_responder (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// bus management lines, true level
	input  wire logic        atn_i,
	input  wire logic        ifc_i,
	input  wire logic        ren_i,
	// data lines
	input  wire logic [7:0]  dio_i,
	output logic [7:0]       dio_o,
	output logic             dio_oe,
	// handshake lines, enable high asserts the line
	input  wire logic        dav_i,
	output logic             dav_o,
	output logic             dav_oe,
	input  wire logic        nrfd_i,
	output logic             nrfd_o,
	output logic             nrfd_oe,
	input  wire logic        ndac_i,
	output logic             ndac_o,
	output logic             ndac_oe,
	// address setting
	input  wire logic        addr_load_i,
	input  wire logic [4:0]  addr_i,
	// configuration
	input  wire logic        cfg_wr_i,
	input  wire logic [31:0] cfg_wdata_i,
	input  wire logic        user_sel_i,
	input  wire logic [31:0] user_cfg_i,
	output logic [31:0]      cfg_q,
	// status byte to poll out
	input  wire logic [7:0]  stb_i,
	// front panel
	input  wire logic [7:0]  panel_i,
	output logic [7:0]       panel_q,
	// state and events
	output logic             remote_q,
	output logic             lockout_q,
	output logic             listen_q,
	output logic             talk_q,
	output logic             spoll_q,
	output logic             clr_q,
	output logic             trig_q,
	output logic             dd_valid_q,
	output logic [7:0]       dd_byte_q
);

	// reset release through two flops; assertion stays asynchronous
	logic [1:0] rs_q;
	logic       rst_n;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_n = rs_q[1];

	// acceptor runs under ATN for commands and while listener for data
	logic       ah_stb;
	logic [7:0] ah_byte;
	logic       ah_nrfd;
	logic       ah_ndac;

	ibr_acceptor u_ah (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.en_i    (atn_i || listen_q),
		.dav_i   (dav_i),
		.dio_i   (dio_i),
		.nrfd_oe (ah_nrfd),
		.ndac_oe (ah_ndac),
		.strobe  (ah_stb),
		.byte_q  (ah_byte)
	);

	typedef struct packed {
		logic             remote;
		logic             lockout;
		logic             listen;
		logic             talk;
		logic             spoll;
		logic [4:0]       addr;
		logic [31:0]      cfg;
		logic             clr;
		logic             trig;
		logic [7:0]       panel;
		logic             ddv;
		logic [7:0]       ddb;
		ibr_pkg::ibr_sh_e sh;
		logic             dav;
		logic [7:0]       dio;
		logic             dio_oe;
		logic             nrfd;
		logic             ndac;
	} ibr_st_s;

	ibr_st_s s_q;
	ibr_st_s s_d;
	logic    cmd;
	logic    do_clr;

	// command interpretation; later assignments win, so clears of state sit last
	always_comb begin
		s_d = s_q;
		s_d.clr = 1'b0;
		s_d.trig = 1'b0;
		s_d.ddv = 1'b0;
		do_clr = 1'b0;
		cmd = ah_stb && atn_i;                             // R24
		if (addr_load_i) begin
			s_d.addr = addr_i;
		end
		if (cfg_wr_i) begin
			s_d.cfg = cfg_wdata_i;
		end
		if (ah_stb && !atn_i && s_q.listen) begin
			s_d.ddv = 1'b1;                                // data goes to the parser
			s_d.ddb = ah_byte;
		end
		if (cmd) begin
			if (ibr_pkg::addr_hit(ah_byte, ibr_pkg::GRP_LISTEN, s_q.addr)) begin
				s_d.listen = 1'b1;                         // R23
				if (ren_i) begin
					s_d.remote = 1'b1;                     // R22
				end
			end
			if (ah_byte[6:5] == ibr_pkg::GRP_TALK) begin
				// own talk address takes talker, any other one drops it
				s_d.talk = ibr_pkg::addr_hit(ah_byte, ibr_pkg::GRP_TALK, s_q.addr); // R23 R20
				if (s_d.talk) begin
					s_d.listen = 1'b0;
				end
			end
			case (ah_byte[6:0])
				ibr_pkg::CMD_UNL: s_d.listen = 1'b0;
				ibr_pkg::CMD_UNT: s_d.talk = 1'b0;
				ibr_pkg::CMD_LLO: s_d.lockout = s_q.lockout | ren_i;        // R5 R7
				ibr_pkg::CMD_DCL: do_clr = 1'b1;                            // R11 R12
				ibr_pkg::CMD_SPE: s_d.spoll = 1'b1;                         // R19
				ibr_pkg::CMD_SPD: s_d.spoll = 1'b0;                         // R19
				ibr_pkg::CMD_GTL: begin
					if (s_q.listen) begin
						s_d.remote = 1'b0;                 // R8 R9 R10
					end
				end
				ibr_pkg::CMD_SDC: do_clr = s_q.listen;                      // R15
				ibr_pkg::CMD_GET: s_d.trig = s_q.listen && ibr_pkg::trig_ok(s_q.cfg); // R16 R17
				default: ;
			endcase
		end
		// a clear outranks a parser write in the same cycle
		if (do_clr) begin
			s_d.cfg = user_sel_i ? user_cfg_i : ibr_pkg::CFG_DEFAULT;  // R11 R13 R14
			s_d.clr = 1'b1;
		end
		// remote enable false is the one road out of lockout
		if (!ren_i) begin
			s_d.remote = 1'b0;
			s_d.lockout = 1'b0;                            // R6
		end
		if (ifc_i) begin
			s_d.remote = 1'b0;                             // R1 R3
			s_d.listen = 1'b0;                             // R1 R2
			s_d.talk = 1'b0;                               // R1 R2
			s_d.spoll = 1'b0;
		end
		// keys pass only while not locked out; power is not in this path
		s_d.panel = s_q.lockout ? 8'h00 : panel_i;         // R4

		// status byte source handshake
		case (s_q.sh)
			ibr_pkg::SH_IDLE: begin
				if (s_q.spoll && s_q.talk && !atn_i) begin
					s_d.dio = stb_i;                       // R18 R21
					s_d.dio_oe = 1'b1;
					s_d.sh = ibr_pkg::SH_WAIT;
				end
			end
			ibr_pkg::SH_WAIT: begin
				if (!nrfd_i && ndac_i) begin
					s_d.dav = 1'b1;
					s_d.sh = ibr_pkg::SH_DAV;
				end
			end
			ibr_pkg::SH_DAV: begin
				if (!ndac_i) begin
					s_d.dav = 1'b0;
					s_d.dio_oe = 1'b0;
					s_d.sh = ibr_pkg::SH_DONE;
				end
			end
			ibr_pkg::SH_DONE: ;
			default: s_d.sh = ibr_pkg::SH_IDLE;
		endcase
		// ATN or loss of poll talker ends the transfer; one byte per addressing
		if (atn_i || !s_q.spoll || !s_q.talk || ifc_i) begin
			s_d.dav = 1'b0;
			s_d.dio_oe = 1'b0;
			s_d.sh = ibr_pkg::SH_IDLE;                     // R20
		end
		// handshake lines mirror the acceptor, registered once more
		s_d.nrfd = ah_nrfd;
		s_d.ndac = ah_ndac;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.addr <= ibr_pkg::ADDR_DEFAULT;             // R23
			s_q.cfg <= ibr_pkg::CFG_DEFAULT;               // R13 R14
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign dio_o      = s_q.dio;
	assign dio_oe     = s_q.dio_oe;
	assign dav_o      = s_q.dav;
	assign dav_oe     = s_q.dav;
	assign nrfd_o     = s_q.nrfd;
	assign nrfd_oe    = s_q.nrfd;
	assign ndac_o     = s_q.ndac;
	assign ndac_oe    = s_q.ndac;
	assign cfg_q      = s_q.cfg;
	assign panel_q    = s_q.panel;
	assign remote_q   = s_q.remote;
	assign lockout_q  = s_q.lockout;
	assign listen_q   = s_q.listen;
	assign talk_q     = s_q.talk;
	assign spoll_q    = s_q.spoll;
	assign clr_q      = s_q.clr;
	assign trig_q     = s_q.trig;
	assign dd_valid_q = s_q.ddv;
	assign dd_byte_q  = s_q.ddb;

	// checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_ifc_idle: assert property (ifc_i |=> !listen_q && !talk_q && !remote_q) // R1
		else $error("interface clear left talker, listener or remote set");
	a_ifc_lamps: assert property ($rose(ifc_i) && $past(talk_q) |=> !talk_q [*1]) // R2
		else $error("talk lamp stayed on after interface clear");
	a_panel_locked: assert property (lockout_q |=> panel_q == 8'h00) // R4
		else $error("front panel key passed during lockout");
	a_llo_ren: assert property ($rose(lockout_q) |-> $past(ren_i)) // R5
		else $error("lockout taken without remote enable");
	a_ren_release: assert property (!ren_i |=> !lockout_q && !remote_q) // R6
		else $error("lockout or remote survived remote enable false");
	a_lockout_holds: assert property (lockout_q && ren_i |=> lockout_q) // R9
		else $error("lockout dropped while remote enable true");
	a_remote_entry: assert property ($rose(remote_q) |-> $past(ren_i) && listen_q) // R22
		else $error("remote entered without listen addressing and remote enable");
	a_clear_default: assert property (clr_q && !$past(user_sel_i) |-> cfg_q == ibr_pkg::CFG_DEFAULT) // R13
		else $error("clear did not restore factory defaults");
	a_trig_mode: assert property (trig_q |-> $past(listen_q) && ibr_pkg::trig_ok($past(cfg_q))) // R16
		else $error("reading triggered outside listener or trigger mode");
	a_poll_drive: assert property ($rose(dio_oe) |-> $past(spoll_q && talk_q && !atn_i)) // R18
		else $error("status byte driven outside a poll read");
	// data and valid may drop together once accepted, so only the rise is checked
	a_poll_dav: assert property ($rose(dav_o) |-> dio_oe && !$past(nrfd_i) && $past(ndac_i)) // R21
		else $error("data valid raised without status byte or ready");

endmodule

// >>> ibr_pkg.sv
// constants, types and helpers shared by the bus command responder files
// assumes bus lines arrive as true-level logic values, already synchronous to mclk
// Behaviour
// R1: interface clear forces local state and idles talker and listener
// R2: interface clear turns off the talk and listen lamps
// R3: controller holds interface clear for at least 100 us
// R4: after lockout every front-panel key is ignored, power excepted
// R5: lockout command is accepted only while remote enable is true
// R6: lockout stays until remote enable goes false, the only way out
// R7: controller sends lockout as ATN plus command byte, no addressing
// R8: go-to-local while listener leaves remote and drops the remote lamp
// R9: go-to-local never clears lockout
// R10: controller sends go-to-local with ATN after listen addressing
// R11: universal device clear restores factory or user defaults always
// R12: controller sends universal device clear as ATN plus command byte
// R13: factory defaults: DC volts, 1000V, prefix, converter, S3, T6, mux, CR LF
// R14: factory defaults: no filter, zero, delay, SRQ; exp filter, K0, Q0, I0
// R15: selective clear acts like device clear but only when listener
// R16: trigger while listener starts one reading in trigger modes that accept it
// R17: controller sends trigger with ATN after listen addressing
// R18: in poll mode, talk addressed and ATN false, drive the status byte
// R19: controller polls with enable, talk address, ATN low, read, disable
// R20: talk addressing and status reads may repeat while poll mode lasts
// R21: status byte goes out on every poll, service request or not
// R22: remote entered only on listen addressing with remote enable true
// R23: primary address defaults to 10, compared with addresses under ATN
// R24: bytes are commands only under ATN; three-wire handshake per byte
package ibr_pkg;

	// bus address
	localparam logic [4:0] ADDR_DEFAULT = 5'h0a;

	// interface commands, bit 7 of the bus byte is ignored
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3f;
	localparam logic [6:0] CMD_UNT = 7'h5f;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK   = 2'h2;

	// minimum interface clear width, held by the controller
	localparam int IFC_MIN_US = 100;

	// configuration word layout
	localparam int CFG_TRIG_LSB = 25;
	localparam logic [2:0] TRIG_GET_A = 3'h2;
	localparam logic [2:0] TRIG_GET_B = 3'h3;

	// factory defaults, field by field from the top bit down
	localparam logic [31:0] CFG_DEFAULT = {
		1'b0,        // data store size: continuous
		1'b0,        // data store rate: one-shot
		1'b0,        // terminator: cr lf
		1'b1,        // multiplex on
		3'h6,        // trigger: continuous on external
		2'h3,        // rate: line cycle, 6.5 digits
		1'b0,        // srq disabled
		1'b0,        // no reading delay
		2'h0,        // zero disabled
		1'b1,        // exponential filter on
		7'h00,       // digital filter off
		1'b0,        // eoi and hold-off on execute enabled
		1'b0,        // reading from converter
		1'b0,        // send prefix
		4'h5,        // range 1000V
		4'h0         // dc volts
	};

	// acceptor and source handshake states
	typedef enum logic [1:0] {
		AH_IDLE  = 2'b00,
		AH_READY = 2'b01,
		AH_ACPT  = 2'b10
	} ibr_ah_e;

	typedef enum logic [1:0] {
		SH_IDLE = 2'b00,
		SH_WAIT = 2'b01,
		SH_DAV  = 2'b10,
		SH_DONE = 2'b11
	} ibr_sh_e;

	// address byte of a given group that carries our address
	function automatic logic addr_hit(input logic [7:0] b, input logic [1:0] grp,
		input logic [4:0] addr);
		addr_hit = (b[6:5] == grp) && (b[4:0] == addr) && (b[4:0] != 5'h1f);
	endfunction

	// trigger modes that act on a bus trigger
	function automatic logic trig_ok(input logic [31:0] cfg);
		logic [2:0] t;
		t = cfg[CFG_TRIG_LSB +: 3];
		trig_ok = (t == TRIG_GET_A) || (t == TRIG_GET_B);
	endfunction

endpackage

// >>> ibr_acceptor.sv
// acceptor handshake: takes one byte per data-valid cycle of the source
// assumes dav_i and dio_i are synchronous; open-drain enables assert the lines
`timescale 1ns/1ps
module ibr_acceptor (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// enable: under ATN or while listener
	input  wire logic       en_i,
	// bus side
	input  wire logic       dav_i,
	input  wire logic [7:0] dio_i,
	output logic            nrfd_oe,
	output logic            ndac_oe,
	// user side
	output logic            strobe,
	output logic [7:0]      byte_q
);

	typedef struct packed {
		ibr_pkg::ibr_ah_e st;
		logic             nrfd;
		logic             ndac;
		logic             stb;
		logic [7:0]       b;
	} ibr_ah_s;

	ibr_ah_s s_q;
	ibr_ah_s s_d;

	// handshake sequencing; a disabled acceptor lets go of both lines
	always_comb begin
		s_d = s_q;
		s_d.stb = 1'b0;
		case (s_q.st)
			ibr_pkg::AH_IDLE: begin
				s_d.nrfd = 1'b0;
				s_d.ndac = 1'b0;
				if (en_i && !dav_i) begin
					s_d.ndac = 1'b1;
					s_d.st = ibr_pkg::AH_READY;
				end
			end
			ibr_pkg::AH_READY: begin
				if (!en_i) begin
					s_d.st = ibr_pkg::AH_IDLE;
				end else if (dav_i) begin
					s_d.b = dio_i;         // R24
					s_d.stb = 1'b1;
					s_d.nrfd = 1'b1;
					s_d.ndac = 1'b0;
					s_d.st = ibr_pkg::AH_ACPT;
				end
			end
			ibr_pkg::AH_ACPT: begin
				// hold not-ready until the source drops data valid
				if (!dav_i) begin
					s_d.ndac = en_i;       // R24
					s_d.nrfd = 1'b0;
					s_d.st = en_i ? ibr_pkg::AH_READY : ibr_pkg::AH_IDLE;
				end
			end
			default: begin
				s_d.st = ibr_pkg::AH_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign nrfd_oe = s_q.nrfd;
	assign ndac_oe = s_q.ndac;
	assign strobe  = s_q.stb;
	assign byte_q  = s_q.b;

endmodule

// >>> ibr_ctl_model.sv
// controller-in-charge model: drives ATN, IFC, REN, sources commands, reads polls
// assumes the bench forms each open-drain line as a true-level wired-OR
`timescale 1ns/1ps
module ibr_ctl_model (
	// clock
	input  wire logic       mclk,
	// wired bus as every party sees it
	input  wire logic       dav_w,
	input  wire logic [7:0] dio_w,
	input  wire logic       nrfd_w,
	input  wire logic       ndac_w,
	// our drive, high asserts
	output logic            atn,
	output logic            ifc,
	output logic            ren,
	output logic            dav,
	output logic [7:0]      dio,
	output logic            nrfd,
	output logic            ndac
);
	int i;

	initial begin
		{atn, ifc, ren, dav, dio, nrfd, ndac} = '0;
	end

	// every change lands the same small delay after the edge
	task automatic nx();
		@(posedge mclk);
		#5;
	endtask

	// ifc and ren levels; ifc hold time is the caller's job
	task automatic lines(input logic f, input logic r);
		ifc = f;
		ren = r;
	endtask

	// one byte: wait ready, hold dav until accepted, then release
	task automatic send(input logic a, input logic [7:0] b);
		atn = a;
		{nrfd, ndac} = 2'b00;
		for (i = 0; i < 40 && !(ndac_w && !nrfd_w); i++) nx();
		if (i == 40) tb_top.tmo();
		dio = b;
		dav = 1'b1;
		for (i = 0; i < 40 && ndac_w; i++) nx();
		if (i == 40) tb_top.tmo();
		dav = 1'b0;
		dio = 8'h00; // released lines are pulled to false
		nx();
	endtask

	// status read with ATN false, acting as acceptor
	task automatic poll(output logic [7:0] b);
		atn = 1'b0;
		{nrfd, ndac} = 2'b01;
		for (i = 0; i < 40 && !dav_w; i++) nx();
		if (i == 40) tb_top.tmo();
		b = dio_w;
		{nrfd, ndac} = 2'b10;
		for (i = 0; i < 40 && dav_w; i++) nx();
		if (i == 40) tb_top.tmo();
		nx();
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the bus command responder against a reference model
// assumes the controller model above and true-level wired-OR bus lines
`timescale 1ns/1ps
module tb_top;
	logic        mclk, arst_n, addr_load, cfg_wr, user_sel, atn, ifc, ren;
	logic        c_dav, c_nrfd, c_ndac, dio_oe, dav_o, dav_oe, nrfd_o, nrfd_oe;
	logic        ndac_o, ndac_oe, remote, lockout, listen, talk, spoll, clr, trig, dd_v;
	logic        e_rem, e_llo, e_lis, e_tlk, e_spl;
	logic [4:0]  addr, my;
	logic [7:0]  c_dio, dio_o, stb, panel, panel_q, dd_b, last_dd, e_ddb, rb;
	logic [31:0] cfg_wdata, user_cfg, cfg_q, e_cfg, x;
	wire  [7:0]  dio_w = c_dio | (dio_oe ? dio_o : 8'h00);
	wire         dav_w = c_dav | (dav_oe & dav_o);
	wire         nrfd_w = c_nrfd | (nrfd_oe & nrfd_o);
	wire         ndac_w = c_ndac | (ndac_oe & ndac_o);
	int          err_total, n_checks, n_clr, n_trig, n_dd, e_clr, e_trig, e_dd, t;
	logic [31:0] seed = 32'hf56a_352f;

	ibr_responder ibr_responder_inst (.mclk(mclk), .arst_n(arst_n), .atn_i(atn),
		.ifc_i(ifc), .ren_i(ren), .dio_i(dio_w), .dio_o(dio_o), .dio_oe(dio_oe),
		.dav_i(dav_w), .dav_o(dav_o), .dav_oe(dav_oe), .nrfd_i(nrfd_w), .nrfd_o(nrfd_o),
		.nrfd_oe(nrfd_oe), .ndac_i(ndac_w), .ndac_o(ndac_o), .ndac_oe(ndac_oe),
		.addr_load_i(addr_load), .addr_i(addr), .cfg_wr_i(cfg_wr), .cfg_wdata_i(cfg_wdata),
		.user_sel_i(user_sel), .user_cfg_i(user_cfg), .cfg_q(cfg_q), .stb_i(stb),
		.panel_i(panel), .panel_q(panel_q), .remote_q(remote), .lockout_q(lockout),
		.listen_q(listen), .talk_q(talk), .spoll_q(spoll), .clr_q(clr), .trig_q(trig),
		.dd_valid_q(dd_v), .dd_byte_q(dd_b));
	ibr_ctl_model ibr_ctl_model_inst (.mclk(mclk), .dav_w(dav_w), .dio_w(dio_w),
		.nrfd_w(nrfd_w), .ndac_w(ndac_w), .atn(atn), .ifc(ifc), .ren(ren), .dav(c_dav),
		.dio(c_dio), .nrfd(c_nrfd), .ndac(c_ndac));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// pulse counters; pulses stand one cycle so every edge is looked at
	always @(posedge mclk) begin
		if (clr === 1'b1) n_clr++;
		if (trig === 1'b1) n_trig++;
		if (dd_v === 1'b1) begin
			n_dd++;
			last_dd = dd_b;
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic test_done();
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic tmo();
		err_total++;
		$display("BAD %0t handshake wait ran out", $time);
		test_done();
	endtask

	task automatic nx();
		@(posedge mclk);
		#5;
	endtask

	// compare tasks, one for each kind of result
	task automatic cmp_st(input logic [4:0] g, input logic [4:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t state %b want %b", $time, g, e);
		end
	endtask

	task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t value %h want %h", $time, g, e);
		end
	endtask

	task automatic cmp_n(input int g, input int e);
		n_checks++;
		if (g != e) begin
			err_total++;
			$display("BAD %0t count %0d want %0d", $time, g, e);
		end
	endtask

	task automatic chk();
		cmp_st({remote, lockout, listen, talk, spoll}, {e_rem, e_llo, e_lis, e_tlk, e_spl});
		cmp_w(cfg_q, e_cfg);
		cmp_n(n_clr, e_clr);
		cmp_n(n_trig, e_trig);
		cmp_n(n_dd, e_dd);
		cmp_w({24'h0, last_dd}, {24'h0, e_ddb});
	endtask

	// reference model of one bus byte, then compare everything
	task automatic cmd(input logic a, input logic [7:0] b);
		logic [6:0] c;
		c = b[6:0];
		ibr_ctl_model_inst.send(a, b);
		if (!a) begin
			if (e_lis) begin
				e_dd++;
				e_ddb = b;
			end
		end else if (c == {2'b01, my}) begin
			e_lis = 1'b1;
			if (ren) e_rem = 1'b1;
		end else if (c == 7'h3f) e_lis = 1'b0;
		else if (c == {2'b10, my}) {e_tlk, e_lis} = 2'b10;
		else if (c[6:5] == 2'b10) e_tlk = 1'b0;
		else if (c == 7'h11 && ren) e_llo = 1'b1;
		else if (c == 7'h14 || (c == 7'h04 && e_lis)) begin
			e_clr++;
			e_cfg = user_sel ? user_cfg : ibr_pkg::CFG_DEFAULT;
		end else if (c == 7'h01 && e_lis) e_rem = 1'b0;
		else if (c == 7'h08 && e_lis && e_cfg[27:26] == 2'b01) e_trig++;
		else if (c == 7'h18) e_spl = 1'b1;
		else if (c == 7'h19) e_spl = 1'b0;
		repeat (2) nx();
		chk();
	endtask

	task automatic wcfg(input logic [31:0] v);
		cfg_wdata = v;
		cfg_wr = 1'b1;
		nx();
		cfg_wr = 1'b0;
		e_cfg = v;
	endtask

	task automatic pan();
		x = rnd();
		panel = x[7:0];
		repeat (2) nx();
		cmp_w({24'h0, panel_q}, {24'h0, e_llo ? 8'h00 : panel});
	endtask

	initial begin
		{arst_n, addr_load, cfg_wr, user_sel, addr, cfg_wdata, user_cfg, stb, panel} = '0;
		{e_rem, e_llo, e_lis, e_tlk, e_spl, last_dd, e_ddb} = '0;
		e_cfg = ibr_pkg::CFG_DEFAULT;
		my = ibr_pkg::ADDR_DEFAULT;
		repeat (2) @(posedge mclk);
		#5 arst_n = 1'b1;
		repeat (3) nx();
		chk();
		cmd(1'b1, 8'h2a);
		cmd(1'b1, 8'h3f);
		ibr_ctl_model_inst.lines(1'b0, 1'b1);
		nx();
		chk();
		cmd(1'b1, 8'h2a);
		cmd(1'b1, 8'h01);
		pan();
		cmd(1'b1, 8'h91);
		pan();
		cmd(1'b1, 8'h2a);
		cmd(1'b1, 8'h01);
		// every trigger mode as listener, then mode 2 only as non-listener
		for (t = 0; t < 8; t++) begin
			x = rnd();
			wcfg({x[31:28], t[2:0], x[24:0]});
			cmd(1'b1, 8'h08);
		end
		x = rnd();
		wcfg({x[31:28], 3'h2, x[24:0]});
		cmd(1'b1, 8'h3f);
		cmd(1'b1, 8'h08);
		cmd(1'b1, 8'h94);
		user_cfg = rnd();
		user_sel = 1'b1;
		wcfg(rnd());
		cmd(1'b1, 8'h04);
		cmd(1'b1, 8'h2a);
		cmd(1'b1, 8'h04);
		user_sel = 1'b0;
		x = rnd();
		cmd(1'b0, x[7:0]);
		// two polls in one poll mode, then clear in the middle of it
		x = rnd();
		stb = x[7:0];
		cmd(1'b1, 8'h18);
		cmd(1'b1, 8'h4a);
		ibr_ctl_model_inst.poll(rb);
		cmp_w({24'h0, rb}, {24'h0, stb});
		x = rnd();
		stb = x[7:0];
		cmd(1'b1, 8'h4a);
		ibr_ctl_model_inst.poll(rb);
		cmp_w({24'h0, rb}, {24'h0, stb});
		ibr_ctl_model_inst.lines(1'b1, 1'b1);
		repeat (2000) nx();
		ibr_ctl_model_inst.lines(1'b0, 1'b1);
		{e_rem, e_lis, e_tlk, e_spl} = '0;
		nx();
		chk();
		cmd(1'b1, 8'h19);
		ibr_ctl_model_inst.lines(1'b0, 1'b0);
		{e_llo, e_rem} = '0;
		repeat (2) nx();
		chk();
		cmd(1'b1, 8'h11);
		// new primary address; old one must stop matching
		x = rnd();
		my = (x[4:0] == 5'h1f || x[4:0] == 5'h0a) ? 5'h03 : x[4:0];
		addr = my;
		addr_load = 1'b1;
		nx();
		addr_load = 1'b0;
		cmd(1'b1, 8'h2a);
		cmd(1'b1, {3'b001, my});
		cmd(1'b1, {3'b010, my});
		cmd(1'b1, 8'h5f);
		test_done();
	end
endmodule
